// ---- hw/lps_ctrl.sv ----
`timescale 1ns/100ps
`include "lps_defs.svh"

module lps_ctrl
  import lps_pkg::*;
#(
  parameter logic [31:0] LIGHT_CYC = 32'(`LPS_LIGHT_MS * 1000000 / `LPS_MCLK_NS),
  parameter logic [31:0] AMB_CYC = 32'(`LPS_AMB_US * 1000 / `LPS_MCLK_NS),
  parameter logic [31:0] EMIT_CYC = 32'(`LPS_EMIT_US * 1000 / `LPS_MCLK_NS),
  parameter logic [31:0] POST_CYC =
    32'((`LPS_REFL_US - `LPS_AMB_US - `LPS_EMIT_US) * 1000 / `LPS_MCLK_NS),
  parameter logic [31:0] SLEEP_CYC = 32'(`LPS_SLEEP_US * 1000 / `LPS_MCLK_NS),
  // Arbitrary identification value
  parameter logic [7:0] CHIP_ID = 8'h5A
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Converter front end
  input wire lps_sense_s sense,
  output lps_drive_s drive,
  // Interrupt pin
  output logic int_n
);

  logic scl_m_q, scl_q, scl_p_q, sda_m_q, sda_q, sda_p_q;
  logic [7:0] pu_cnt_q;
  lps_bus_e bst_q, bst_d;
  logic [3:0] bcnt_q, bcnt_d;
  logic [7:0] bsh_q, bsh_d, ptr_q, ptr_d;
  logic back_q, back_d, oe_q, oe_d, nak_q, nak_d, wr_stb;
  lps_cfg_s cfg_q;
  logic [1:0] pprst_q, lprst_q;
  logic ictl_q, lflag_q, pflag_q, int_n_q;
  logic [7:0] rlt_q, rht_q, th5_q, th6_q, th7_q, rcount_q, roff_q, ron_q;
  logic [11:0] lcount_q;
  logic [31:0] lt_cnt_q, pc_q;
  lps_prox_e pst_q, pst_d;
  logic [4:0] lrun_q, phi_q, plo_q;
  lps_drive_s drv_q;

  // Pin synchronisers; the first stage only feeds the second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_m_q, scl_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_q, sda_p_q} <= 3'h7;
    end else begin
      {scl_m_q, scl_q, scl_p_q} <= {scl_in, scl_m_q, scl_q};
      {sda_m_q, sda_q, sda_p_q} <= {sda_in, sda_m_q, sda_q};
    end
  end

  wire scl_rise = scl_q & ~scl_p_q;
  wire scl_fall = ~scl_q & scl_p_q;
  wire start_det = scl_q & scl_p_q & sda_p_q & ~sda_q;
  wire stop_det = scl_q & scl_p_q & ~sda_p_q & sda_q;

  wire pu_done = (pu_cnt_q == 8'(`LPS_PWRUP_CYC));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pu_cnt_q <= 8'h00;
    end else if (!pu_done) begin
      pu_cnt_q <= pu_cnt_q + 8'h01;
    end
  end

  // Register read selection
  function automatic logic [7:0] rd_reg(input logic [7:0] a);
    if (a == `LPS_REG_ID) rd_reg = CHIP_ID;
    else if (a == `LPS_REG_CFG) rd_reg = cfg_q;
    else if (a == `LPS_REG_IRQ) rd_reg = {pflag_q, pprst_q, 1'b0, lflag_q, lprst_q, ictl_q};
    else if (a == `LPS_REG_RLT) rd_reg = rlt_q;
    else if (a == `LPS_REG_RHT) rd_reg = rht_q;
    else if (a == `LPS_REG_TH5) rd_reg = th5_q;
    else if (a == `LPS_REG_TH6) rd_reg = th6_q;
    else if (a == `LPS_REG_TH7) rd_reg = th7_q;
    else if (a == `LPS_REG_RCNT) rd_reg = rcount_q;
    else if (a == `LPS_REG_LCL) rd_reg = lcount_q[7:0];
    else if (a == `LPS_REG_LCH) rd_reg = {4'h0, lcount_q[11:8]};
    else rd_reg = 8'h00;
  endfunction : rd_reg

  // Pointer rolls back to the first register past the last one
  wire [7:0] ptr_next = (ptr_q == `LPS_REG_LCH) ? `LPS_REG_ID : ptr_q + 8'h01;
  logic [7:0] rd_data, rd_next;

  // A function in a continuous assignment would only wake on its argument
  always_comb begin
    rd_data = rd_reg(ptr_q);
    rd_next = rd_reg(ptr_next);
  end

  // slave byte engine, msb first in both directions
  always_comb begin
    bst_d = bst_q;
    bcnt_d = bcnt_q;
    bsh_d = bsh_q;
    back_d = back_q;
    ptr_d = ptr_q;
    oe_d = oe_q;
    nak_d = nak_q;
    wr_stb = 1'b0;
    if (start_det && pu_done) begin
      bst_d = B_ADDR;
      bcnt_d = 4'h0;
      back_d = 1'b0;
      oe_d = 1'b0;
    end else if (stop_det) begin
      bst_d = B_IDLE;
      back_d = 1'b0;
      oe_d = 1'b0;
    end else if (bst_q == B_RDAT) begin
      if (scl_rise) begin
        bcnt_d = bcnt_q + 4'h1;
        if (bcnt_q == `LPS_BYTE_BITS) nak_d = sda_q;
      end else if (scl_fall) begin
        if (bcnt_q == `LPS_ACK_SLOT) begin
          ptr_d = ptr_next;
          bcnt_d = 4'h0;
          if (nak_q) begin
            bst_d = B_IDLE;
            oe_d = 1'b0;
          end else begin
            bsh_d = rd_next;
            oe_d = ~rd_next[7];
          end
        end else if (bcnt_q == `LPS_BYTE_BITS) begin
          oe_d = 1'b0;
        end else begin
          bsh_d = {bsh_q[6:0], 1'b0};
          oe_d = ~bsh_q[6];
        end
      end
    end else if (bst_q != B_IDLE) begin
      if (scl_rise && !back_q) begin
        bsh_d = {bsh_q[6:0], sda_q};
        bcnt_d = bcnt_q + 4'h1;
      end else if (scl_fall && back_q) begin
        back_d = 1'b0;
        oe_d = 1'b0;
        bcnt_d = 4'h0;
        if (bst_q == B_ADDR && bsh_q[0]) begin
          bst_d = B_RDAT;
          bsh_d = rd_data;
          oe_d = ~rd_data[7];
        end else if (bst_q == B_ADDR) begin
          bst_d = B_REG;
        end else begin
          if (bst_q == B_WDAT) ptr_d = ptr_next;
          bst_d = B_WDAT;
        end
      end else if (scl_fall && bcnt_q == `LPS_BYTE_BITS) begin
        if (bst_q == B_ADDR && bsh_q[7:1] != `LPS_DEV_ADDR) begin
          bst_d = B_IDLE;
        end else begin
          back_d = 1'b1;
          oe_d = 1'b1;
        end
        if (bst_q == B_REG) ptr_d = bsh_q;
        if (bst_q == B_WDAT) wr_stb = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bst_q <= B_IDLE;
      bcnt_q <= 4'h0;
      bsh_q <= 8'h00;
      ptr_q <= 8'h00;
      {back_q, oe_q, nak_q} <= 3'h0;
    end else begin
      bst_q <= bst_d;
      bcnt_q <= bcnt_d;
      bsh_q <= bsh_d;
      ptr_q <= ptr_d;
      {back_q, oe_q, nak_q} <= {back_d, oe_d, nak_d};
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;

  // Register write decode
  wire wr_cfg = wr_stb && (ptr_q == `LPS_REG_CFG);
  wire wr_irq = wr_stb && (ptr_q == `LPS_REG_IRQ);
  wire wr_rlt = wr_stb && (ptr_q == `LPS_REG_RLT);
  wire wr_rht = wr_stb && (ptr_q == `LPS_REG_RHT);
  wire wr_th5 = wr_stb && (ptr_q == `LPS_REG_TH5);
  wire wr_th6 = wr_stb && (ptr_q == `LPS_REG_TH6);
  wire wr_th7 = wr_stb && (ptr_q == `LPS_REG_TH7);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `LPS_RST_ZERO;
      {pprst_q, lprst_q, ictl_q} <= 5'h00;
      rlt_q <= `LPS_RST_ZERO;
      rht_q <= `LPS_RST_ZERO;
      th5_q <= `LPS_RST_ZERO;
      th6_q <= `LPS_RST_TH6;
      th7_q <= `LPS_RST_TH7;
    end else begin
      if (wr_cfg) cfg_q <= bsh_q;
      if (wr_irq) pprst_q <= bsh_q[`LPS_F_PPRST];
      if (wr_irq) lprst_q <= bsh_q[`LPS_F_LPRST];
      if (wr_irq) ictl_q <= bsh_q[`LPS_F_ICTL];
      if (wr_rlt) rlt_q <= bsh_q;
      if (wr_rht) rht_q <= bsh_q;
      if (wr_th5) th5_q <= bsh_q;
      if (wr_th6) th6_q <= bsh_q;
      if (wr_th7) th7_q <= bsh_q;
    end
  end

  wire light_done = cfg_q.light_enable && (lt_cnt_q == LIGHT_CYC - 32'h0000_0001);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lt_cnt_q <= 32'h0000_0000;
      lcount_q <= 12'h000;
    end else begin
      lt_cnt_q <= (light_done || !cfg_q.light_enable) ? 32'h0000_0000
                                                      : lt_cnt_q + 32'h0000_0001;
      if (light_done) lcount_q <= sense.light_adc;
    end
  end

  wire [31:0] sleep_len = SLEEP_CYC << (`LPS_SLEEP_TOP - cfg_q.reflect_sleep_select);
  wire [31:0] plen = (pst_q == P_AMB) ? AMB_CYC :
                     (pst_q == P_EMIT) ? EMIT_CYC :
                     (pst_q == P_POST) ? POST_CYC : sleep_len;
  // Not an equality test: a sleep field shortened mid-sleep must not strand the count
  wire pend = (pc_q >= plen - 32'h0000_0001);
  wire refl_done = (pst_q == P_POST) && pend && cfg_q.refl_en;

  always_comb begin
    pst_d = pst_q;
    case (pst_q)
      P_IDLE: pst_d = P_AMB;
      P_AMB: if (pend) pst_d = P_EMIT;
      P_EMIT: if (pend) pst_d = P_POST;
      P_POST: if (pend) pst_d = P_SLEEP;
      P_SLEEP: if (pend) pst_d = P_AMB;
      default: pst_d = P_IDLE;
    endcase
    if (!cfg_q.refl_en) pst_d = P_IDLE;
  end

  wire [7:0] refl_diff = (ron_q > roff_q) ? ron_q - roff_q : 8'h00;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pst_q <= P_IDLE;
      pc_q <= 32'h0000_0000;
      roff_q <= 8'h00;
      ron_q <= 8'h00;
      rcount_q <= 8'h00;
    end else begin
      pst_q <= pst_d;
      pc_q <= (pst_d != pst_q || pend) ? 32'h0000_0000 : pc_q + 32'h0000_0001;
      if (pst_q == P_AMB && pend) roff_q <= sense.refl_adc;
      if (pst_q == P_EMIT && pend) ron_q <= sense.refl_adc;
      if (refl_done) rcount_q <= refl_diff;
    end
  end

  // persistency code to required run length
  function automatic logic [4:0] prst_len(input logic [1:0] code);
    case (code)
      2'h0: prst_len = 5'h01;
      2'h1: prst_len = 5'h04;
      2'h2: prst_len = 5'h08;
      default: prst_len = 5'h10;
    endcase
  endfunction : prst_len

  function automatic logic [4:0] run_inc(input logic [4:0] r);
    run_inc = (r == `LPS_PRST_MAX) ? r : r + 5'h01;
  endfunction : run_inc

  // window test on the fresh light sample
  wire [11:0] light_lo = {th6_q[3:0], th5_q};
  wire [11:0] light_hi = {th7_q, th6_q[7:4]};
  wire light_out = (sense.light_adc < light_lo) || (sense.light_adc > light_hi);
  wire [4:0] lrun_n = run_inc(lrun_q);
  wire lset = light_done && light_out && (lrun_n >= prst_len(lprst_q));

  wire refl_hi = refl_diff > rht_q;
  wire refl_lo = refl_diff < rlt_q;
  wire [4:0] phi_n = run_inc(phi_q);
  wire [4:0] plo_n = run_inc(plo_q);
  wire pset = refl_done && refl_hi && (phi_n >= prst_len(pprst_q));
  wire pclr = refl_done && refl_lo && (plo_n >= prst_len(pprst_q));

  // writing zero clears a flag; a new set wins
  wire lf_wclr = wr_irq && !bsh_q[`LPS_F_LFLAG];
  wire pf_wclr = wr_irq && !bsh_q[`LPS_F_PFLAG];

  // flag combine, pin only after persistency
  wire irq_any = ictl_q ? (lflag_q & pflag_q) : (lflag_q | pflag_q);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lrun_q <= 5'h00;
      phi_q <= 5'h00;
      plo_q <= 5'h00;
      lflag_q <= 1'b0;
      pflag_q <= 1'b0;
      int_n_q <= 1'b1;
    end else begin
      // runs advance per conversion, reset on a miss
      if (light_done) lrun_q <= light_out ? lrun_n : 5'h00;
      if (refl_done) phi_q <= refl_hi ? phi_n : 5'h00;
      if (refl_done) plo_q <= refl_lo ? plo_n : 5'h00;
      lflag_q <= lset | (lflag_q & ~lf_wclr);
      pflag_q <= pset | (pflag_q & ~pclr & ~pf_wclr);
      int_n_q <= ~irq_any;
    end
  end

  assign int_n = int_n_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drv_q <= '0;
    end else begin
      drv_q.emitter_drive_pin <= (pst_d == P_EMIT);
      drv_q.emit_high <= cfg_q.emitter_drive_select;
      drv_q.light_run <= cfg_q.light_enable;
      drv_q.light_ir_select <= cfg_q.light_ir_select;
      drv_q.light_range_select <= cfg_q.light_range_select;
    end
  end

  assign drive = drv_q;

endmodule : lps_ctrl

// ---- hw/lps_defs.svh ----
`ifndef LPS_DEFS_SVH
`define LPS_DEFS_SVH

`define LPS_MCLK_NS 4
`define LPS_LIGHT_MS 100
`define LPS_REFL_US 540
`define LPS_EMIT_US 100
`define LPS_AMB_US 220
`define LPS_SLEEP_US 6250
`define LPS_PWRUP_US 1
`define LPS_PWRUP_CYC (`LPS_PWRUP_US * 1000 / `LPS_MCLK_NS)

`define LPS_REG_ID 8'h00
`define LPS_REG_CFG 8'h01
`define LPS_REG_IRQ 8'h02
`define LPS_REG_RLT 8'h03
`define LPS_REG_RHT 8'h04
`define LPS_REG_TH5 8'h05
`define LPS_REG_TH6 8'h06
`define LPS_REG_TH7 8'h07
`define LPS_REG_RCNT 8'h08
`define LPS_REG_LCL 8'h09
`define LPS_REG_LCH 8'h0A

`define LPS_RST_ZERO 8'h00
`define LPS_RST_TH6 8'hF0
`define LPS_RST_TH7 8'hFF

`define LPS_F_PFLAG 7
`define LPS_F_PPRST 6:5
`define LPS_F_LFLAG 3
`define LPS_F_LPRST 2:1
`define LPS_F_ICTL 0

`define LPS_DEV_ADDR 7'h44
`define LPS_BYTE_BITS 4'h8
`define LPS_ACK_SLOT 4'h9
`define LPS_SLEEP_TOP 3'h7
`define LPS_PRST_MAX 5'h10

`endif

// ---- hw/lps_pkg.sv ----
package lps_pkg;

  typedef enum logic [2:0] {
    P_IDLE = 3'b000,
    P_AMB = 3'b001,
    P_EMIT = 3'b010,
    P_POST = 3'b011,
    P_SLEEP = 3'b100
  } lps_prox_e;

  typedef enum logic [2:0] {
    B_IDLE = 3'b000,
    B_ADDR = 3'b001,
    B_REG = 3'b010,
    B_WDAT = 3'b011,
    B_RDAT = 3'b100
  } lps_bus_e;

  typedef struct packed {
    logic refl_en;
    logic [2:0] reflect_sleep_select;
    logic emitter_drive_select;
    logic light_enable;
    logic light_range_select;
    logic light_ir_select;
  } lps_cfg_s;

  typedef struct packed {
    logic [11:0] light_adc;
    logic [7:0] refl_adc;
  } lps_sense_s;

  typedef struct packed {
    logic emitter_drive_pin;
    logic emit_high;
    logic light_run;
    logic light_ir_select;
    logic light_range_select;
  } lps_drive_s;

endpackage : lps_pkg

// ---- testbench/lps_ctrl_monitor.sv ----
`timescale 1ns/100ps
module lps_ctrl_monitor
  import lps_pkg::*;
#(
  parameter logic [31:0] AMB_CYC = 32'h0000_000A,
  parameter logic [31:0] EMIT_CYC = 32'h0000_0005,
  parameter logic [31:0] POST_CYC = 32'h0000_000A,
  parameter logic [31:0] SLEEP_CYC = 32'h0000_0004
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Front end and interrupt
  input wire lps_sense_s sense,
  input wire lps_drive_s drive,
  input wire logic int_n
);
  logic [8:0] up_q;
  logic [7:0] on_q;
  logic [15:0] gap_q;
  logic [4:0] hi_q;
  wire logic pin = drive.emitter_drive_pin;
  wire logic [3:0] cfg_w = {drive.emit_high, drive.light_run, drive.light_ir_select,
                            drive.light_range_select};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      up_q <= '0;
      on_q <= '0;
      gap_q <= '1;
      hi_q <= '0;
    end else begin
      up_q <= (up_q == 9'h1FF) ? up_q : up_q + 9'h001;
      on_q <= pin ? on_q + 8'h01 : 8'h00;
      gap_q <= pin ? 16'h0000 : ((gap_q == 16'hFFFF) ? gap_q : gap_q + 16'h0001);
      // A long high clock means an idle bus
      hi_q <= !scl_in ? 5'h00 : ((hi_q == 5'h1F) ? hi_q : hi_q + 5'h01);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_reset_out: assert property ($rose(rst_n) |-> drive == 5'h00 && int_n)
    else $error("outputs not idle after reset");
  a_blank_quiet: assert property (up_q < 9'h0FA |-> !sda_oe && int_n)
    else $error("bus answered during power-up blanking");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("data pin changed while clock high");
  a_oe_hold: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("data pull released too early");
  a_idle_release: assert property (hi_q >= 5'h18 |-> !sda_oe)
    else $error("data pin held on idle bus");
  a_emit_width: assert property ($fell(pin) |-> on_q == EMIT_CYC[7:0])
    else $error("emitter pulse length wrong");
  a_emit_gap: assert property ($rose(pin) |-> gap_q >= 16'(AMB_CYC + POST_CYC + SLEEP_CYC))
    else $error("emitter pulses too close");
  a_cfg_by_write: assert property ($changed(cfg_w) |-> sda_oe || $past(sda_oe))
    else $error("drive settings changed without a write");
endmodule : lps_ctrl_monitor

bind lps_ctrl lps_ctrl_monitor #(.AMB_CYC(AMB_CYC), .EMIT_CYC(EMIT_CYC), .POST_CYC(POST_CYC),
  .SLEEP_CYC(SLEEP_CYC)) u_lps_ctrl_monitor (.mclk(mclk), .rst_n(rst_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .sense(sense), .drive(drive),
  .int_n(int_n));

// ---- testbench/lps_ctrl_tb.sv ----
`timescale 1ns/100ps
module lps_ctrl_tb
  import lps_pkg::*;
;
  // Arbitrary identification value
  localparam logic [7:0] ID_VAL = 8'h3C;
  localparam logic [6:0] DEV = 7'h44;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] light_val = 12'h000;
  logic [7:0] refl_on = 8'h00;
  logic [7:0] refl_off = 8'h00;
  wire logic scl_w, sda_w;
  logic sda_out, sda_oe, int_n;
  lps_drive_s drive;
  lps_sense_s sense;
  int miscompares = 0;
  int num_checks = 0;
  wire logic [7:0] dsel = {4'h0, drive.emit_high, drive.light_run, drive.light_ir_select,
                           drive.light_range_select};
  always #2 mclk = !mclk;
  // Front end: the reflect reading switches to refl_on while the emitter is lit
  assign sense = {light_val, drive.emitter_drive_pin ? refl_on : refl_off};
  lps_ctrl #(.LIGHT_CYC(32'h0000_00C8), .AMB_CYC(32'h0000_000A), .EMIT_CYC(32'h0000_0005),
    .POST_CYC(32'h0000_000A), .SLEEP_CYC(32'h0000_0004), .CHIP_ID(ID_VAL)) u_lps_ctrl (
    .mclk(mclk), .rst_n(rst_n), .scl_in(scl_w), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .sense(sense), .drive(drive), .int_n(int_n));
  lps_i2c_master u_lps_i2c_master (.mclk(mclk), .sda_oe(sda_oe), .scl(scl_w), .sda(sda_w));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : check8
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_lps_i2c_master.wr_reg(DEV, a, d, ok);
    check8("write ack", 8'h01, {7'h00, ok});
  endtask : wr
  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic ok;
    logic [7:0] d;
    u_lps_i2c_master.rd_reg(DEV, a, d, ok);
    check8("read ack", 8'h01, {7'h00, ok});
    check8(what, exp, d);
  endtask : rd
  task automatic t_blank();
    logic ok;
    u_lps_i2c_master.wr_reg(DEV, 8'h03, 8'h77, ok);
    check8("early start ack", 8'h00, {7'h00, ok});
    tick(300);
    rd("early write dropped", 8'h03, 8'h00);
  endtask : t_blank
  task automatic t_regs();
    logic [7:0] rv [11] = '{ID_VAL, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hF0, 8'hFF,
                            8'h00, 8'h00, 8'h00};
    logic [7:0] sa [4] = '{8'h01, 8'h0F, 8'h0E, 8'h0F};
    logic [7:0] sd [4] = '{8'h00, 8'h29, 8'h00, 8'h00};
    logic ok;
    for (int i = 0; i < 4; i++) wr(sa[i], sd[i]);
    for (int i = 0; i < 11; i++) rd("reset value", 8'(i), rv[i]);
    wr(8'h08, 8'h55);
    rd("count is read only", 8'h08, 8'h00);
    rd("unmapped", 8'h0C, 8'h00);
    wr(8'h05, 8'hA5);
    u_lps_i2c_master.wr_reg(7'h45, 8'h05, 8'h3C, ok);
    check8("foreign address ack", 8'h00, {7'h00, ok});
    rd("foreign write dropped", 8'h05, 8'hA5);
    check8("data value", 8'h00, {7'h00, sda_out});
  endtask : t_regs
  task automatic t_config();
    logic [7:0] cv [3] = '{8'h0F, 8'h05, 8'h00};
    logic [7:0] ev [3] = '{8'h0F, 8'h06, 8'h00};
    for (int i = 0; i < 3; i++) begin
      wr(8'h01, cv[i]);
      check8("drive fields", ev[i], dsel);
    end
    rd("config readback", 8'h01, 8'h00);
  endtask : t_config
  task automatic t_reflect();
    time t0;
    logic lit;
    refl_on = 8'h50;
    refl_off = 8'h20;
    wr(8'h04, 8'h10);
    wr(8'h03, 8'h08);
    wr(8'h02, 8'h00);
    wr(8'h01, 8'hF0);
    tick(100);
    rd("reflect count", 8'h08, 8'h30);
    rd("reflect flag set", 8'h02, 8'h80);
    check8("pin either flag", 8'h00, {7'h00, int_n});
    refl_off = 8'h60;
    tick(100);
    rd("reflect floor", 8'h08, 8'h00);
    rd("reflect flag cleared", 8'h02, 8'h00);
    check8("pin released", 8'h01, {7'h00, int_n});
    wr(8'h01, 8'hD0);
    @(posedge drive.emitter_drive_pin);
    t0 = $time;
    @(posedge drive.emitter_drive_pin);
    check8("reflect period", 8'h29, 8'(($time - t0) / 4));
    tick(2);
    wr(8'h01, 8'h00);
    lit = 1'b0;
    repeat (80) begin
      tick(1);
      lit = lit | drive.emitter_drive_pin;
    end
    check8("power down", 8'h00, {7'h00, lit});
  endtask : t_reflect
  task automatic t_light();
    wr(8'h05, 8'h00);
    wr(8'h06, 8'h01);
    wr(8'h07, 8'h80);
    light_val = 12'h456;
    wr(8'h01, 8'h04);
    tick(500);
    rd("light low byte", 8'h09, 8'h56);
    rd("light high byte", 8'h0A, 8'h04);
    rd("light in window", 8'h02, 8'h00);
    wr(8'h02, 8'h02);
    light_val = 12'h900;
    // At most three results fit in this wait
    tick(500);
    check8("persistency hold", 8'h01, {7'h00, int_n});
    tick(400);
    check8("persistency met", 8'h00, {7'h00, int_n});
    wr(8'h02, 8'h0B);
    check8("both flags needed", 8'h01, {7'h00, int_n});
    rd("light flag set", 8'h02, 8'h0B);
    wr(8'h02, 8'h0A);
    check8("either flag", 8'h00, {7'h00, int_n});
    light_val = 12'h456;
    tick(500);
    check8("flag holds", 8'h00, {7'h00, int_n});
    wr(8'h02, 8'h02);
    rd("light flag cleared", 8'h02, 8'h02);
    check8("pin idle", 8'h01, {7'h00, int_n});
    // Bright visible reading on the low range: host moves to the high range
    light_val = 12'h800;
    tick(400);
    rd("bright high byte", 8'h0A, 8'h08);
    wr(8'h01, 8'h06);
    check8("range switched", 8'h05, dsel);
  endtask : t_light
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  initial begin
    tick(16);
    rst_n = 1'b1;
    t_blank();
    t_regs();
    t_config();
    t_reflect();
    t_light();
    conclude();
  end
  // The tests need about half this span
  initial begin
    repeat (90000) @(posedge mclk);
    miscompares++;
    conclude();
  end
endmodule : lps_ctrl_tb

// ---- testbench/lps_i2c_master.sv ----
`timescale 1ns/100ps
module lps_i2c_master (
  // Clock
  input wire logic mclk,
  // Bus wires
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  localparam int HALF = 10;
  logic m_low = 1'b0;
  // Pull-up: a released wire reads high
  assign sda = !(m_low || sda_oe);
  initial scl = 1'b1;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic start_c();
    m_low = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    m_low = 1'b1;
    tick(HALF);
    scl = 1'b0;
    tick(2);
  endtask : start_c
  task automatic stop_c();
    m_low = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    m_low = 1'b0;
    tick(HALF);
  endtask : stop_c
  // Data moves only while the clock is low, never at its edge
  task automatic bit_io(input logic b, output logic r);
    m_low = !b;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    r = sda;
    scl = 1'b0;
    tick(2);
  endtask : bit_io
  task automatic send(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(1'b1, r);
    ack = !r;
  endtask : send
  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                        output logic ok);
    logic [7:0] rx;
    logic k1, k2, k3;
    start_c();
    send({dev, 1'b0}, rx, k1);
    send(a, rx, k2);
    send(d, rx, k3);
    stop_c();
    ok = k1 && k2 && k3;
  endtask : wr_reg
  // Single byte read, ended by a refusal from the master
  task automatic rd_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d,
                        output logic ok);
    logic [7:0] rx;
    logic k1, k2, k3, k4;
    start_c();
    send({dev, 1'b0}, rx, k1);
    send(a, rx, k2);
    start_c();
    send({dev, 1'b1}, rx, k3);
    send(8'hFF, d, k4);
    stop_c();
    ok = k1 && k2 && k3;
  endtask : rd_reg
endmodule : lps_i2c_master
